/* pkg/rci_cfg.svh */
// constants for the register command interpreter
`ifndef RCI_CFG_SVH
`define RCI_CFG_SVH
// ===========================================
// register byte offsets
`define RCI_OFF_ARG_A 8'h00
`define RCI_OFF_ARG_B 8'h04
`define RCI_OFF_ARG_C 8'h08
`define RCI_OFF_CMD   8'h0C
`define RCI_OFF_STAT  8'h10
`define RCI_OFF_RES   8'h14
`define RCI_OFF_STEPS 8'h18
`define RCI_OFF_FACT  8'h1C
`define RCI_OFF_REM   8'h20
// ===========================================
// command word fields and opcodes
`define RCI_CMD_OP    3:0
`define RCI_CMD_SUB   5:4
`define RCI_CMD_AREG  6
`define RCI_CMD_BREG  7
`define RCI_OP_SETPRE 4'h1
`define RCI_OP_ARITH  4'h2
`define RCI_OP_VERIFY 4'h3
`define RCI_OP_INIT   4'h4
`define RCI_OP_CONV   4'h5
`define RCI_OP_MOVE   4'h6
`define RCI_OP_PRINT  4'h7
`define RCI_OP_DELAY  4'h8
// ===========================================
// status bits
`define RCI_ST_BUSY   0
`define RCI_ST_DIV    1
`define RCI_ST_RNG    2
`define RCI_ST_OVF    3
`define RCI_ST_DLY    4
// ===========================================
// limits and arguments
`define RCI_IDX_LAST  16'h01FE
`define RCI_ADR_FIRST 9'h001
`define RCI_ADR_LAST  9'h1FE
`define RCI_WORD_MAX  32'h0000FFFF
`define RCI_DIV_MAX   16'h7FFF
`define RCI_PRE_LAST  16'h0004
`define RCI_INIT_CLR  16'h0005
`define RCI_INIT_SAVE 16'h0006
`define RCI_INIT_LOAD 16'h0007
`define RCI_FACT_ONE  40'h0000002710
`define RCI_FACT_MIN  24'h000001
`define RCI_FACT_MAX  24'hF42400
`define RCI_DEST_MIN  16'h0001
`define RCI_DEST_MAX  16'h001F
`define RCI_DEST_HOST 16'h00FF
// ===========================================
// timing: delay unit and clock period in ns
`define RCI_TICK_NS   10000000
`define RCI_CLK_NS    20
`endif

/* pkg/rci_pkg.sv */
// types for the register command interpreter
package rci_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_RD_A, ST_RD_B, ST_EXEC,
		ST_VERIFY, ST_BULK, ST_MOVE, ST_WAIT
	} rci_state_t;
	typedef enum logic [1:0] {
		ALU_ADD, ALU_SUB, ALU_MUL, ALU_DIV
	} rci_alu_t;
	typedef enum logic [1:0] {
		PK_REG, PK_LIT, PK_TEXT, PK_BAD
	} rci_kind_t;
endpackage : rci_pkg

/* hdl/rci_regfile.sv */
// user register array with its nonvolatile shadow copy
module rci_regfile #(
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic          ref_clk,
	input  wire logic [AW-1:0] addr,
	input  wire logic          we,
	input  wire logic [15:0]   wdata,
	input  wire logic          nv_st,
	input  wire logic          nv_ld,
	output logic      [15:0]   rdata
);
	if (DEPTH < 511 || DEPTH > (1 << AW))
		$error("rci_regfile: depth does not fit 510 registers");

	// memories carry no reset; bulk clear is a command
	logic [15:0] mem [DEPTH];
	logic [15:0] nv  [DEPTH];

	// ===========================================
	// working copy: write wins over recall
	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end else if (nv_ld) begin
			mem[addr] <= nv[addr];
		end
	end

	// shadow copy, one entry per cycle
	always_ff @(posedge ref_clk) begin
		if (nv_st) begin
			nv[addr] <= mem[addr];
		end
	end

	// synchronous read, one cycle after address
	always_ff @(posedge ref_clk) begin
		rdata <= mem[addr];
	end
endmodule : rci_regfile

/* hdl/rci_top.sv */
// register command interpreter with avalon-mm slave
//
// Local design decisions: the address map and register access over Avalon-MM.
`include "rci_cfg.svh"
module rci_top #(
	parameter int TICK_CYCLES = `RCI_TICK_NS / `RCI_CLK_NS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        home_done,
	output logic             move_valid,
	output logic      [31:0] move_steps,
	output logic             print_valid,
	output logic             print_host,
	output logic      [4:0]  print_module,
	output logic      [15:0] print_target,
	output logic      [15:0] print_data,
	output logic      [1:0]  print_kind,
	output logic      [15:0] ramp_steps,
	output logic      [15:0] start_rate,
	output logic      [15:0] top_rate,
	output logic      [15:0] loop_count,
	output logic             delay_active
);
	if (TICK_CYCLES < 2 || TICK_CYCLES > 24'hFFFFFF)
		$error("rci_top: tick count out of range");
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

	rci_pkg::rci_state_t state;
	rci_pkg::rci_alu_t   alu;
	logic [15:0] arg_a, arg_b, arg_c, delay_reg, result;
	logic [15:0] lit_a, lit_b, opa_val, opb, rf_rdata, rf_wdata;
	logic [3:0]  op_q, cmd_op;
	logic [8:0]  rf_addr, dst_q;
	logic        rf_we, nv_st, nv_ld, a_reg, b_reg;
	logic        wr_acc, cmd_go, cmd_bad, alu_bad, div_bad;
	logic        err_div, err_rng, err_ovf;
	logic [23:0] factor, fval, tick_cnt;
	logic [13:0] remainder;
	logic [39:0] move_total;
	logic [31:0] alu_res, rd_mux;
	logic [1:0]  kind;
	logic        home_s1, home_s2, home_s3, home_edge;
	logic [15:0] lit_delay;

	// ===========================================
	// avalon slave: one wait cycle, then answer
	assign wr_acc = avs_write && !avs_waitrequest;
	assign cmd_go = wr_acc && avs_address == `RCI_OFF_CMD
		&& avs_byteenable[0];
	assign cmd_op = avs_writedata[`RCI_CMD_OP];
	assign kind   = avs_writedata[`RCI_CMD_SUB];
	assign fval   = {arg_a[7:0], arg_b};

	// writes stall while busy so latched operands stay put
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read
			|| (avs_write && state == rci_pkg::ST_IDLE)) begin
			avs_waitrequest <= 1'b0;
		end
	end

	// read data is captured as waitrequest drops
	always_comb begin
		case (avs_address)
		`RCI_OFF_ARG_A: rd_mux = {16'h0000, arg_a};
		`RCI_OFF_ARG_B: rd_mux = {16'h0000, arg_b};
		`RCI_OFF_ARG_C: rd_mux = {16'h0000, arg_c};
		`RCI_OFF_STAT:  rd_mux = {27'h0000000, delay_active,
			err_ovf, err_rng, err_div, state != rci_pkg::ST_IDLE};
		`RCI_OFF_RES:   rd_mux = {16'h0000, result};
		`RCI_OFF_STEPS: rd_mux = move_steps;
		`RCI_OFF_FACT:  rd_mux = {8'h00, factor};
		`RCI_OFF_REM:   rd_mux = {18'h00000, remainder};
		default:        rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// argument registers honour the two low byte lanes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arg_a <= 16'h0000;
			arg_b <= 16'h0000;
			arg_c <= 16'h0000;
		end else if (wr_acc) begin
			for (int i = 0; i < 2; i++) begin
				if (avs_byteenable[i]) begin
					case (avs_address)
					`RCI_OFF_ARG_A: arg_a[i*8 +: 8] <= avs_writedata[i*8 +: 8];
					`RCI_OFF_ARG_B: arg_b[i*8 +: 8] <= avs_writedata[i*8 +: 8];
					`RCI_OFF_ARG_C: arg_c[i*8 +: 8] <= avs_writedata[i*8 +: 8];
					default: ;
					endcase
				end
			end
		end
	end

	// ===========================================
	// command screening before anything changes
	always_comb begin
		case (cmd_op)
		`RCI_OP_SETPRE: cmd_bad = arg_a > `RCI_PRE_LAST;
		`RCI_OP_ARITH:  cmd_bad = arg_a == 16'h0000
			|| arg_a > `RCI_IDX_LAST
			|| (avs_writedata[`RCI_CMD_AREG] && arg_b > `RCI_IDX_LAST)
			|| (avs_writedata[`RCI_CMD_BREG] && arg_c > `RCI_IDX_LAST);
		`RCI_OP_VERIFY: cmd_bad = arg_a > `RCI_IDX_LAST;
		`RCI_OP_INIT:   cmd_bad = arg_a < `RCI_INIT_CLR
			|| arg_a > `RCI_INIT_LOAD;
		`RCI_OP_CONV:   cmd_bad = fval < `RCI_FACT_MIN
			|| fval > `RCI_FACT_MAX;
		`RCI_OP_PRINT:  cmd_bad = !((arg_a >= `RCI_DEST_MIN
			&& arg_a <= `RCI_DEST_MAX) || arg_a == `RCI_DEST_HOST)
			|| kind == 2'(rci_pkg::PK_BAD)
			|| (kind == 2'(rci_pkg::PK_REG)
			&& arg_c > `RCI_IDX_LAST);
		`RCI_OP_MOVE:   cmd_bad = 1'b0;
		`RCI_OP_DELAY:  cmd_bad = 1'b0;
		default:        cmd_bad = 1'b1;
		endcase
	end

	// ===========================================
	// arithmetic on 16-bit unsigned values
	assign opb = b_reg ? rf_rdata : lit_b;
	always_comb begin
		alu_res = 32'h00000000;
		div_bad = 1'b0;
		case (alu)
		rci_pkg::ALU_ADD: alu_res = {16'h0000, opa_val} + {16'h0000, opb};
		rci_pkg::ALU_SUB: alu_res = {16'h0000, opa_val} - {16'h0000, opb};
		rci_pkg::ALU_MUL: alu_res = {16'h0000, opa_val} * {16'h0000, opb};
		rci_pkg::ALU_DIV: begin
			// integer divide drops the fraction
			if (opb != 16'h0000)
				alu_res = {16'h0000, opa_val / opb};
			div_bad = opa_val > `RCI_DIV_MAX || opb > `RCI_DIV_MAX
				|| opb == 16'h0000;
		end
		default: ;
		endcase
	end
	// out of range results are refused, not wrapped
	assign alu_bad = div_bad || alu_res > `RCI_WORD_MAX
		|| (alu == rci_pkg::ALU_SUB && opb > opa_val);

	// ===========================================
	// sequencer; no mode input gates any command
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state      <= rci_pkg::ST_IDLE;
			op_q       <= 4'h0;
			alu        <= rci_pkg::ALU_ADD;
			a_reg      <= 1'b0;
			b_reg      <= 1'b0;
			lit_a      <= 16'h0000;
			lit_b      <= 16'h0000;
			opa_val    <= 16'h0000;
			dst_q      <= 9'h000;
			rf_addr    <= 9'h000;
			rf_we      <= 1'b0;
			rf_wdata   <= 16'h0000;
			nv_st      <= 1'b0;
			nv_ld      <= 1'b0;
			result     <= 16'h0000;
			move_total <= 40'h0000000000;
		end else begin
			rf_we <= 1'b0;
			case (state)
			rci_pkg::ST_IDLE: if (cmd_go && !cmd_bad) begin
				op_q <= cmd_op;
				case (cmd_op)
				`RCI_OP_ARITH: begin
					alu   <= rci_pkg::rci_alu_t'(kind);
					a_reg <= avs_writedata[`RCI_CMD_AREG];
					b_reg <= avs_writedata[`RCI_CMD_BREG];
					dst_q <= arg_a[8:0];
					lit_a <= arg_b;
					lit_b <= arg_c;
					rf_addr <= arg_b[8:0];
					state <= rci_pkg::ST_RD_A;
				end
				`RCI_OP_VERIFY: begin
					lit_a   <= arg_a;
					rf_addr <= arg_a[8:0];
					state   <= rci_pkg::ST_RD_A;
				end
				`RCI_OP_PRINT: if (kind == 2'(rci_pkg::PK_REG)) begin
					lit_a   <= arg_c;
					rf_addr <= arg_c[8:0];
					state   <= rci_pkg::ST_RD_A;
				end
				`RCI_OP_INIT: begin
					// any mode may start a bulk pass
					rf_addr  <= `RCI_ADR_FIRST;
					rf_wdata <= 16'h0000;
					rf_we    <= arg_a == `RCI_INIT_CLR;
					nv_st    <= arg_a == `RCI_INIT_SAVE;
					nv_ld    <= arg_a == `RCI_INIT_LOAD;
					state    <= rci_pkg::ST_BULK;
				end
				`RCI_OP_MOVE: begin
					move_total <= {24'h000000, arg_a}
						* {16'h0000, factor}
						+ {26'h0000000, remainder};
					state <= rci_pkg::ST_MOVE;
				end
				`RCI_OP_DELAY: state <= rci_pkg::ST_WAIT;
				default: ;
				endcase
			end
			rci_pkg::ST_RD_A: begin
				rf_addr <= lit_b[8:0];
				state <= op_q == `RCI_OP_ARITH ? rci_pkg::ST_RD_B
					: rci_pkg::ST_VERIFY;
			end
			rci_pkg::ST_RD_B: begin
				opa_val <= a_reg ? rf_rdata : lit_a;
				state   <= rci_pkg::ST_EXEC;
			end
			rci_pkg::ST_EXEC: begin
				rf_addr <= dst_q;
				if (!alu_bad) begin
					rf_we    <= 1'b1;
					rf_wdata <= alu_res[15:0];
					result   <= alu_res[15:0];
				end
				state <= rci_pkg::ST_IDLE;
			end
			rci_pkg::ST_VERIFY: begin
				// index 0 names no user register
				if (op_q == `RCI_OP_VERIFY)
					result <= lit_a == 16'h0000 ? 16'h0000
						: rf_rdata;
				state <= rci_pkg::ST_IDLE;
			end
			rci_pkg::ST_BULK: begin
				// one register per cycle, 1 through 510
				if (rf_addr == `RCI_ADR_LAST) begin
					nv_st <= 1'b0;
					nv_ld <= 1'b0;
					state <= rci_pkg::ST_IDLE;
				end else begin
					rf_we   <= rf_we;
					rf_addr <= rf_addr + 9'h001;
				end
			end
			rci_pkg::ST_MOVE: state <= rci_pkg::ST_IDLE;
			rci_pkg::ST_WAIT: if (!delay_active)
				state <= rci_pkg::ST_IDLE;
			default: state <= rci_pkg::ST_IDLE;
			endcase
		end
	end

	rci_regfile #(
		.DEPTH (512),
		.AW    (9)
	) u_regs (
		.ref_clk (ref_clk),
		.addr    (rf_addr),
		.we      (rf_we),
		.wdata   (rf_wdata),
		.nv_st   (nv_st),
		.nv_ld   (nv_ld),
		.rdata   (rf_rdata)
	);

	// ===========================================
	// sticky errors: a new event beats the clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_div <= 1'b0;
			err_rng <= 1'b0;
			err_ovf <= 1'b0;
		end else begin
			if (wr_acc && avs_address == `RCI_OFF_STAT) begin
				err_div <= err_div & ~avs_writedata[`RCI_ST_DIV];
				err_rng <= err_rng & ~avs_writedata[`RCI_ST_RNG];
				err_ovf <= err_ovf & ~avs_writedata[`RCI_ST_OVF];
			end
			if (state == rci_pkg::ST_EXEC && div_bad)
				err_div <= 1'b1;
			if (state == rci_pkg::ST_EXEC && alu_bad && !div_bad)
				err_ovf <= 1'b1;
			if (cmd_go && cmd_bad)
				err_rng <= 1'b1;
		end
	end

	// ===========================================
	// predefined motion registers, direct load
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ramp_steps <= 16'h0000;
			start_rate <= 16'h0000;
			top_rate   <= 16'h0000;
			loop_count <= 16'h0000;
			delay_reg  <= 16'h0000;
		end else if (cmd_go && !cmd_bad
			&& cmd_op == `RCI_OP_SETPRE) begin
			case (arg_a[2:0])
			3'h0: ramp_steps <= arg_b;
			3'h1: start_rate <= arg_b;
			3'h2: top_rate   <= arg_b;
			3'h3: loop_count <= arg_b;
			default: delay_reg <= arg_b;
			endcase
		end
	end

	// conversion factor in units of 0.0001 step
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			factor <= 24'(`RCI_FACT_ONE);
		end else if (cmd_go && !cmd_bad && cmd_op == `RCI_OP_CONV) begin
			factor <= fval;
		end
	end

	// ===========================================
	// homing input from a pin: two stages first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			home_s1 <= 1'b0;
			home_s2 <= 1'b0;
			home_s3 <= 1'b0;
		end else begin
			home_s1 <= home_done;
			home_s2 <= home_s1;
			home_s3 <= home_s2;
		end
	end
	assign home_edge = home_s2 && !home_s3;

	// step split; homing clears after a same-cycle move
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			move_valid <= 1'b0;
			move_steps <= 32'h00000000;
			remainder  <= 14'h0000;
		end else begin
			move_valid <= state == rci_pkg::ST_MOVE;
			if (state == rci_pkg::ST_MOVE) begin
				move_steps <= 32'(move_total / `RCI_FACT_ONE);
				remainder  <= 14'(move_total % `RCI_FACT_ONE);
			end
			if (home_edge)
				remainder <= 14'h0000;
		end
	end

	// ===========================================
	// print strobe; register source waits on a read
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			print_valid  <= 1'b0;
			print_host   <= 1'b0;
			print_module <= 5'h00;
			print_target <= 16'h0000;
			print_data   <= 16'h0000;
			print_kind   <= 2'h0;
		end else begin
			print_valid <= 1'b0;
			if (cmd_go && !cmd_bad && cmd_op == `RCI_OP_PRINT) begin
				print_host   <= arg_a == `RCI_DEST_HOST;
				print_module <= arg_a[4:0];
				print_target <= arg_b;
				print_kind   <= kind;
				print_data   <= kind == 2'(rci_pkg::PK_TEXT)
					? {8'h00, arg_c[7:0]} : arg_c;
				print_valid  <= kind != 2'(rci_pkg::PK_REG);
			end
			if (state == rci_pkg::ST_VERIFY && op_q == `RCI_OP_PRINT) begin
				print_data  <= lit_a == 16'h0000 ? 16'h0000 : rf_rdata;
				print_valid <= 1'b1;
			end
		end
	end

	// ===========================================
	// delay: counts 10 ms ticks of the delay register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			delay_active <= 1'b0;
			tick_cnt     <= 24'h000000;
			lit_delay    <= 16'h0000;
		end else if (cmd_go && !cmd_bad && cmd_op == `RCI_OP_DELAY) begin
			tick_cnt     <= 24'h000000;
			lit_delay    <= delay_reg;
			delay_active <= delay_reg != 16'h0000;
		end else if (delay_active) begin
			if (tick_cnt == TICK_LAST) begin
				tick_cnt  <= 24'h000000;
				lit_delay <= lit_delay - 16'h0001;
				if (lit_delay == 16'h0001)
					delay_active <= 1'b0;
			end else begin
				tick_cnt <= tick_cnt + 24'h000001;
			end
		end
	end

	// ===========================================
	// checks
	sequence s_div_go;
		state == rci_pkg::ST_EXEC && alu == rci_pkg::ALU_DIV && !alu_bad;
	endsequence
	sequence s_div_store(logic [15:0] q);
		rf_we && rf_wdata == q;
	endsequence
	a_div_trunc: assert property (@(posedge ref_clk) disable iff (rst)
		s_div_go |=> s_div_store($past(opa_val) / $past(opb)))
		else $error("division result not truncated");
	a_div_error: assert property (@(posedge ref_clk) disable iff (rst)
		state == rci_pkg::ST_EXEC && alu == rci_pkg::ALU_DIV
		&& opa_val > `RCI_DIV_MAX |=> err_div && !rf_we)
		else $error("large division operand not flagged");
	a_bad_reject: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_go && cmd_bad |=> state == rci_pkg::ST_IDLE && err_rng
		&& $stable(factor))
		else $error("rejected command changed state");
	a_bulk_step: assert property (@(posedge ref_clk) disable iff (rst)
		state == rci_pkg::ST_BULK && rf_addr != `RCI_ADR_LAST
		|=> rf_addr == $past(rf_addr) + 9'h001)
		else $error("bulk pass skipped a register");
	a_bulk_end: assert property (@(posedge ref_clk) disable iff (rst)
		state == rci_pkg::ST_BULK && rf_addr == `RCI_ADR_LAST
		|=> state == rci_pkg::ST_IDLE && !nv_st && !nv_ld && !rf_we)
		else $error("bulk pass ran past register 510");
	a_move_split: assert property (@(posedge ref_clk) disable iff (rst)
		state == rci_pkg::ST_MOVE && !home_edge |=> move_valid
		&& remainder < 14'(`RCI_FACT_ONE))
		else $error("step remainder not reduced");
	a_home_clear: assert property (@(posedge ref_clk) disable iff (rst)
		home_edge |=> remainder == 14'h0000)
		else $error("homing left a remainder");
	a_print_host: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_go && !cmd_bad && cmd_op == `RCI_OP_PRINT
		&& kind == 2'(rci_pkg::PK_LIT) && arg_a == `RCI_DEST_HOST
		|=> print_valid && print_host && print_data == $past(arg_c))
		else $error("host print not issued");
	a_print_reg: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_go && !cmd_bad && cmd_op == `RCI_OP_PRINT
		&& kind == 2'(rci_pkg::PK_REG) |=> !print_valid ##2 print_valid)
		else $error("register print not issued on time");
	a_wait_ack: assert property (@(posedge ref_clk) disable iff (rst)
		avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read not answered in one cycle");
endmodule : rci_top

/* dv/rci_far_end.sv */
// far-side model: host link, module bus listeners and homing switch
// ===========================================
// listeners latch each frame; homing switch pulses on request
module rci_far_end (
	input  wire logic        ref_clk,
	input  wire logic        print_valid,
	input  wire logic        print_host,
	input  wire logic [4:0]  print_module,
	input  wire logic [15:0] print_target,
	input  wire logic [15:0] print_data,
	input  wire logic [1:0]  print_kind,
	input  wire logic        move_valid,
	input  wire logic [31:0] move_steps,
	output logic             home_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [39:0] last_print;
	logic [31:0] last_move;
	int          n_print = 0;
	initial home_done = 1'b0;
	// a frame exists only in its one strobe cycle
	always @(posedge ref_clk) begin
		if (print_valid === 1'b1) begin
			last_print <= {print_host, print_module, print_target,
				print_data, print_kind};
			n_print <= n_print + 1;
		end
		if (move_valid === 1'b1) begin
			last_move <= move_steps;
		end
	end
	// switch held long enough for the two-stage sync
	task home();
		@(posedge ref_clk);
		home_done <= 1'b1;
		repeat (4) @(posedge ref_clk);
		home_done <= 1'b0;
	endtask : home
endmodule : rci_far_end

/* dv/tb_register_command_interpreter.sv */
// self-checking bench for the register command interpreter
`include "rci_cfg.svh"
module tb_register_command_interpreter;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata, move_steps, q;
	logic        avs_waitrequest, home_done, move_valid, print_valid;
	logic        print_host, delay_active;
	logic [4:0]  print_module;
	logic [15:0] print_target, print_data, ramp_steps, start_rate;
	logic [15:0] top_rate, loop_count;
	logic [1:0]  print_kind;
	int          err_count = 0;
	int          samples_checked = 0;
	int          dly_n = 0;
	// ===========================================
	// clock, design and far side
	initial forever #10 ref_clk = ~ref_clk;
	rci_top #(.TICK_CYCLES(4)) u_dut (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .home_done(home_done),
		.move_valid(move_valid), .move_steps(move_steps),
		.print_valid(print_valid), .print_host(print_host),
		.print_module(print_module), .print_target(print_target),
		.print_data(print_data), .print_kind(print_kind),
		.ramp_steps(ramp_steps), .start_rate(start_rate),
		.top_rate(top_rate), .loop_count(loop_count),
		.delay_active(delay_active));
	rci_far_end far (.ref_clk(ref_clk), .print_valid(print_valid),
		.print_host(print_host), .print_module(print_module),
		.print_target(print_target), .print_data(print_data),
		.print_kind(print_kind), .move_valid(move_valid),
		.move_steps(move_steps), .home_done(home_done));
	// length of each delay, in cycles of delay_active
	always @(posedge ref_clk) begin
		if (delay_active === 1'b1) begin
			dly_n <= dly_n + 1;
		end
	end
	// ===========================================
	// helpers
	task check(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one avalon cycle; held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task args(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		bus(1'b1, `RCI_OFF_ARG_A, {16'h0000, a});
		bus(1'b1, `RCI_OFF_ARG_B, {16'h0000, b});
		bus(1'b1, `RCI_OFF_ARG_C, {16'h0000, c});
	endtask : args
	// issue a command and poll busy; the watchdog bounds a hang
	task cmd(input logic [31:0] w);
		bus(1'b1, `RCI_OFF_CMD, w);
		q = 32'h00000001;
		while (q[0] !== 1'b0) begin
			bus(1'b0, `RCI_OFF_STAT, 32'h00000000);
		end
	endtask : cmd
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(q, exp);
	endtask : rd_chk
	task vr(input logic [15:0] i);
		args(i, 16'h0000, 16'h0000);
		cmd(32'h00000003);
	endtask : vr
	// ===========================================
	// scenarios
	task t_reset();
		rd_chk(`RCI_OFF_FACT, 32'h00002710);
		rd_chk(`RCI_OFF_REM, 32'h00000000);
		rd_chk(`RCI_OFF_CMD, 32'h00000000);
		rd_chk(8'hF0, 32'h00000000);
	endtask : t_reset
	task t_arith();
		args(16'h0002, 16'h0121, 16'h000A); // 289/10, operands small
		cmd(32'h00000032);
		vr(16'h0002);
		rd_chk(`RCI_OFF_RES, 32'h0000001C);
		args(16'h0004, 16'h0002, 16'h0064);
		cmd(32'h00000042);
		vr(16'h0004);
		rd_chk(`RCI_OFF_RES, 32'h00000080);
		args(16'h0002, 16'h9C40, 16'h0002);
		cmd(32'h00000032);
		rd_chk(`RCI_OFF_STAT, 32'h00000002);
		vr(16'h0002);
		rd_chk(`RCI_OFF_RES, 32'h0000001C);
		vr(16'h01FF);
		rd_chk(`RCI_OFF_STAT, 32'h00000006);
		bus(1'b1, `RCI_OFF_STAT, 32'h0000000E);
		rd_chk(`RCI_OFF_STAT, 32'h00000000);
	endtask : t_arith
	task t_init();
		args(16'h0006, 16'h0000, 16'h0000);
		cmd(32'h00000004);
		args(16'h0005, 16'h0000, 16'h0000);
		cmd(32'h00000004);
		vr(16'h0004);
		rd_chk(`RCI_OFF_RES, 32'h00000000);
		args(16'h0007, 16'h0000, 16'h0000);
		cmd(32'h00000004);
		vr(16'h0004);
		rd_chk(`RCI_OFF_RES, 32'h00000080);
	endtask : t_init
	task t_pre();
		for (int s = 0; s < 4; s++) begin
			args(s[15:0], 16'(1000 + s), 16'h0000);
			cmd(32'h00000001);
		end
		check({ramp_steps, start_rate}, 32'h03E803E9);
		check({top_rate, loop_count}, 32'h03EA03EB);
		args(16'h0004, 16'h0002, 16'h0000);
		cmd(32'h00000001);
		dly_n = 0;
		cmd(32'h00000008);
		check(dly_n == 8, 1'b1);
	endtask : t_pre
	task t_move();
		args(16'h0002, 16'h3C6C, 16'h0000);
		cmd(32'h00000005);
		rd_chk(`RCI_OFF_FACT, 32'h00023C6C);
		args(16'h0122, 16'h0000, 16'h0000);
		cmd(32'h00000006);
		check(far.last_move, 32'h00001099);
		rd_chk(`RCI_OFF_REM, 32'h000019C8);
		args(16'h0012, 16'h0000, 16'h0000);
		cmd(32'h00000006);
		check(far.last_move, 32'h00000108);
		rd_chk(`RCI_OFF_REM, 32'h000010E0);
		far.home();
		repeat (6) @(posedge ref_clk);
		rd_chk(`RCI_OFF_REM, 32'h00000000);
		args(16'h00F4, 16'h2401, 16'h0000);
		cmd(32'h00000005);
		rd_chk(`RCI_OFF_FACT, 32'h00023C6C);
		args(16'h00F4, 16'h2400, 16'h0000);
		cmd(32'h00000005);
		rd_chk(`RCI_OFF_FACT, 32'h00F42400);
		bus(1'b1, `RCI_OFF_STAT, 32'h0000000E);
	endtask : t_move
	task t_print();
		args(16'h00FF, 16'h0000, 16'h04D2);
		cmd(32'h00000017);
		check({far.last_print[39], far.last_print[33:0]},
			{1'b1, 16'h0000, 16'h04D2, 2'h1});
		args(16'h0005, 16'h0029, 16'h0004);
		cmd(32'h00000007);
		check(far.last_print, {1'b0, 5'h05, 16'h0029, 16'h0080, 2'h0});
		args(16'h0003, 16'h0029, 16'h004B);
		cmd(32'h00000027);
		check(far.last_print, {1'b0, 5'h03, 16'h0029, 16'h004B, 2'h2});
		args(16'h0020, 16'h0000, 16'h0001);
		cmd(32'h00000017);
		check(far.n_print, 3);
		rd_chk(`RCI_OFF_STAT, 32'h00000004);
	endtask : t_print
	// ===========================================
	// verdict and run control
	task report_and_stop();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	// the whole sequence needs well under 20000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_arith();
		t_init();
		t_pre();
		t_move();
		t_print();
		report_and_stop();
	end
endmodule : tb_register_command_interpreter
